//--- design/pulse_interval_params.svh
// constants for the pulse interval capture channel
// assumes inclusion by bare name from design files
`ifndef PULSE_INTERVAL_PARAMS_SVH
`define PULSE_INTERVAL_PARAMS_SVH

// register offsets on the plain register port
`define OFS_CONTROL   4'h0
`define OFS_COUNTER   4'h1
`define OFS_CAPTURE   4'h2
`define OFS_STATUS    4'h3
`define OFS_MASK      4'h4

// control field positions
`define CTL_START_BIT 0
`define CTL_CCS_BIT   1
`define CTL_STOP_BIT  2

// status field positions
`define STS_CAPTURE_BIT  0
`define STS_OVERRUN_BIT  1
`define STS_RUNNING_BIT  2

// reset values
`define COUNTER_RESET 16'h0000
`define CAPTURE_RESET 16'h0000
`define MASK_RESET    2'h0

`define COUNTER_WIDTH 16
`define IRQ_BITS      2

`endif

//--- design/pulse_interval_pkg.sv
// types for the pulse interval capture channel
// assumes nothing beyond a SystemVerilog compiler
package pulse_interval_pkg;

  typedef enum logic [1:0]
  {
    CH_IDLE,
    CH_WAIT_FIRST,
    CH_MEASURE
  } chan_state_t;

endpackage : pulse_interval_pkg

//--- design/edge_sync.sv
// two-stage synchroniser with rising edge pulse
// assumes the input is asynchronous to sys_clk
`timescale 1ns/1ps
module edge_sync
(
  input  wire logic sys_clk,  // system clock
  input  wire logic reset_n,  // async reset, active low
  input  wire logic pinIn,    // raw asynchronous pin
  output logic      level,    // synchronised level
  output logic      rise      // one-cycle rising edge pulse
);

  logic stage1;
  logic stage2;
  logic prev;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      prev   <= 1'b0;
    end
    else
    begin
      stage1 <= pinIn;
      stage2 <= stage1;
      prev   <= stage2;
    end
  end

  assign level = stage2;
  assign rise  = stage2 & ~prev;

endmodule : edge_sync

//--- design/pulse_interval_capture.sv
// one timer channel measuring intervals between input pulse edges
// assumes a single sys_clk domain and an asynchronous pulse pin
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "pulse_interval_params.svh"

// Notes on behaviour
// - start bit clears counter, counting begins
// - valid edge copies counter to capture
// - capture raises capture-complete interrupt
// - after capture counter clears, keeps counting
// - only rising edges trigger capture
// - counter ticks at operation clock
// - counter read-only; capture read/write
// - count select: clock or pin edges
module pulse_interval_capture
#(
  parameter int COUNT_WIDTH = `COUNTER_WIDTH  // counter width
)
(
  input  wire logic        sys_clk,     // 40 MHz system clock
  input  wire logic        reset_n,     // async reset, active low
  input  wire logic [3:0]  regAddr,     // register index
  input  wire logic [15:0] regWdata,    // write data
  input  wire logic        regWrite,    // write strobe
  input  wire logic        regRead,     // read strobe
  output logic      [15:0] regRdata,    // read data, cycle after
  input  wire logic        pulseInputPin, // external pulse pin
  output logic             captureCompleteIrq // level interrupt
);

  // refuse widths the 16-bit register port cannot carry
  if (COUNT_WIDTH < 1 || COUNT_WIDTH > 16)
  begin : g_width_check
    $error("COUNT_WIDTH must be 1 to 16");
  end

  // ************************************************
  // pin synchronisation and edge detection
  // ************************************************
  logic pinLevel;
  logic pinRise;

  edge_sync u_sync
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pinIn   (pulseInputPin),
    .level   (pinLevel),
    .rise    (pinRise)
  );

  // ************************************************
  // register decode
  // ************************************************
  pulse_interval_pkg::chan_state_t state;
  logic                   countSelect;
  logic [COUNT_WIDTH-1:0] channelCounter;
  logic [COUNT_WIDTH-1:0] captureData;
  logic [`IRQ_BITS-1:0]   irqStatus;
  logic [`IRQ_BITS-1:0]   irqMask;
  logic                   running;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    hit = (a == o);
  endfunction : hit

  logic wrCtl;
  logic wrCap;
  logic wrSts;
  logic wrMask;
  logic startCmd;
  logic stopCmd;

  assign wrCtl    = regWrite & hit(regAddr, `OFS_CONTROL);
  assign wrCap    = regWrite & hit(regAddr, `OFS_CAPTURE);
  assign wrSts    = regWrite & hit(regAddr, `OFS_STATUS);
  assign wrMask   = regWrite & hit(regAddr, `OFS_MASK);
  assign startCmd = wrCtl & regWdata[`CTL_START_BIT];
  assign stopCmd  = wrCtl & regWdata[`CTL_STOP_BIT] & ~startCmd;

  // ************************************************
  // channel state
  // ************************************************
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= pulse_interval_pkg::CH_IDLE;
    else if (startCmd)
      state <= pulse_interval_pkg::CH_WAIT_FIRST;
    else if (stopCmd)
      state <= pulse_interval_pkg::CH_IDLE;
    else
    begin
      case (state)
        pulse_interval_pkg::CH_IDLE:
          state <= pulse_interval_pkg::CH_IDLE;
        pulse_interval_pkg::CH_WAIT_FIRST:
          if (pinRise)
            state <= pulse_interval_pkg::CH_MEASURE;
        pulse_interval_pkg::CH_MEASURE:
          state <= pulse_interval_pkg::CH_MEASURE;
        default:
          state <= pulse_interval_pkg::CH_IDLE;
      endcase
    end
  end

  assign running = (state != pulse_interval_pkg::CH_IDLE);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      countSelect <= 1'b0;
    else if (wrCtl)
      countSelect <= regWdata[`CTL_CCS_BIT];
  end

  // ************************************************
  // counter and capture
  // ************************************************
  logic captureEvent;
  logic countTick;

  assign captureEvent = running & pinRise & ~startCmd;
  // operation clock is undivided sys_clk, or pin edges
  assign countTick = countSelect ? pinRise : 1'b1;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      channelCounter <= COUNT_WIDTH'(`COUNTER_RESET);
    else if (startCmd)
      channelCounter <= COUNT_WIDTH'(`COUNTER_RESET);
    else if (captureEvent)
      channelCounter <= COUNT_WIDTH'(`COUNTER_RESET);
    else if (running && countTick)
      channelCounter <= channelCounter + 1'b1;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      captureData <= COUNT_WIDTH'(`CAPTURE_RESET);
    else if (captureEvent)
      captureData <= channelCounter;
    else if (wrCap)
      captureData <= regWdata[COUNT_WIDTH-1:0];
  end

  // ************************************************
  // interrupts
  // ************************************************
  logic overrun;

  // capture while previous capture flag still pending
  assign overrun = captureEvent & irqStatus[`STS_CAPTURE_BIT];

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      irqStatus <= '0;
    else
    begin
      // set wins over write-one-to-clear
      irqStatus[`STS_CAPTURE_BIT] <= captureEvent |
        (irqStatus[`STS_CAPTURE_BIT] & ~(wrSts &
          regWdata[`STS_CAPTURE_BIT]));
      irqStatus[`STS_OVERRUN_BIT] <= overrun |
        (irqStatus[`STS_OVERRUN_BIT] & ~(wrSts &
          regWdata[`STS_OVERRUN_BIT]));
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      irqMask <= `MASK_RESET;
    else if (wrMask)
      irqMask <= regWdata[`IRQ_BITS-1:0];
  end

  assign captureCompleteIrq = |(irqStatus & irqMask);

  // ************************************************
  // read port
  // ************************************************
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      regRdata <= 16'h0000;
    else if (regRead)
    begin
      case (regAddr)
        `OFS_CONTROL:
          regRdata <= {14'h0000, countSelect, 1'b0};
        `OFS_COUNTER:
          regRdata <= 16'(channelCounter);
        `OFS_CAPTURE:
          regRdata <= 16'(captureData);
        `OFS_STATUS:
          regRdata <= {12'h000, pinLevel, running, irqStatus};
        `OFS_MASK:
          regRdata <= {14'h0000, irqMask};
        default:
          regRdata <= 16'h0000;
      endcase
    end
    else
      regRdata <= 16'h0000;
  end

endmodule : pulse_interval_capture

//--- sim/pulse_interval_capture_properties.sv
// port checker for pulse_interval_capture
// assumes bind onto the top module
`timescale 1ns/1ps
module pulse_interval_capture_properties
#(
  parameter int COUNT_WIDTH = 16  // counter width
)
(
  input wire logic        sys_clk,           // clock
  input wire logic        reset_n,           // reset
  input wire logic [3:0]  regAddr,           // index
  input wire logic [15:0] regWdata,          // wdata
  input wire logic        regWrite,          // write
  input wire logic        regRead,           // read
  input wire logic [15:0] regRdata,          // rdata
  input wire logic        pulseInputPin,     // pin
  input wire logic        captureCompleteIrq // irq
);
  logic       run;
  logic       ccs;
  logic [1:0] msk;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ****
  // shadows of run state, count select and mask
  // ****
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) run <= 1'b0;
    else if (regWrite && regAddr == 4'h0)
      run <= regWdata[0] | (run & ~regWdata[2]);
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) ccs <= 1'b0;
    else if (regWrite && regAddr == 4'h0) ccs <= regWdata[1];
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) msk <= 2'h0;
    else if (regWrite && regAddr == 4'h4) msk <= regWdata[1:0];
  a_rdata_idle: assert property (!regRead |=> regRdata == 16'h0000)
    else $error("read data not idle");
  a_start_clears: assert property (regWrite && regAddr == 4'h0
    && regWdata[0] ##1 regRead && regAddr == 4'h1 |=> regRdata == 16'h0000)
    else $error("counter not cleared by start");
  a_count_ticks: assert property ((!pulseInputPin)[*6] ##0
    (run && !ccs && regRead && regAddr == 4'h1) ##1
    (regRead && regAddr == 4'h1)
    |=> regRdata == $past(regRdata) + 16'h0001)
    else $error("counter not ticking");
  a_edge_capture: assert property (run && msk[0]
    && $rose(pulseInputPin) |-> ##[2:6] captureCompleteIrq)
    else $error("no capture after rising edge");
  a_falls_ignored: assert property ((!pulseInputPin && !regWrite
    && !captureCompleteIrq)[*6] |=> !captureCompleteIrq)
    else $error("interrupt without rising edge");
  a_counter_ro: assert property (regWrite && regAddr == 4'h1
    ##1 regRead && regAddr == 4'h1 |=> regRdata != $past(regWdata, 2))
    else $error("counter took a write");
  a_capture_rw: assert property (!run && regWrite && regAddr == 4'h2
    ##1 regRead && regAddr == 4'h2 |=> regRdata == $past(regWdata, 2))
    else $error("capture write lost");
  a_mask_gates: assert property (msk == 2'h0 |-> !captureCompleteIrq)
    else $error("masked interrupt raised");
  cover property ($rose(captureCompleteIrq));
  cover property ($fell(pulseInputPin));
  cover property (regRead && regAddr == 4'h2);
endmodule : pulse_interval_capture_properties

//--- sim/pulse_source.sv
// behavioural pulse source on the timer input pin
// assumes fire strobes from the bench
`timescale 1ns/1ps
module pulse_source
(
  input  wire logic        fire,   // start one pulse
  input  wire logic [15:0] highNs, // high time, ns
  output logic             pin     // pulse pin
);
  initial pin = 1'b0;
  always @(posedge fire)
  begin
    #7 pin = 1'b1;
    #(highNs) pin = 1'b0;
  end
endmodule : pulse_source

//--- sim/pulse_interval_capture_tb.sv
// bench for pulse_interval_capture
// assumes pulse_source as the pin driver
`timescale 1ns/1ps
module pulse_interval_capture_tb;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [15:0] regRdata;
  logic        pin;
  logic        irq;
  logic        fire = 1'b0;
  logic [15:0] highNs = 16'h0064;
  logic [15:0] d;
  int          num_errors = 0;
  int          samples_checked = 0;
  pulse_interval_capture i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .pulseInputPin(pin),
    .captureCompleteIrq(irq));
  pulse_source i_src (.fire(fire), .highNs(highNs), .pin(pin));
  initial forever #12.5 sys_clk = ~sys_clk;
  // ****
  // bus and check tasks
  // ****
  task automatic check(input string w, input logic [15:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", w, e, s);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic pulse();
    fire <= 1'b1;
    cyc(1);
    fire <= 1'b0;
  endtask : pulse
  // ****
  // scenarios
  // ****
  task automatic resetValues();
    for (int i = 1; i < 6; i++)
    begin
      rd(i == 5 ? 4'hf : i[3:0]);
      check("reset read", d, 16'h0000);
    end
  endtask : resetValues
  task automatic measure();
    wr(4'h4, 16'h0001);
    wr(4'h0, 16'h0001);
    rd(4'h1);
    check("start count", d, 16'h0000);
    rd(4'h1);
    check("tick", d, 16'h0001);
    pulse();
    cyc(10);
    check("irq", {15'h0000, irq}, 16'h0001);
    wr(4'h3, 16'h0001);
    cyc(88);
    check("irq clear", {15'h0000, irq}, 16'h0000);
    pulse();
    cyc(10);
    rd(4'h2);
    check("interval", d, 16'h0063);
    rd(4'h3);
    check("status", d, 16'h0005);
  endtask : measure
  task automatic fallAndMask();
    highNs = 16'h03e8;
    wr(4'h3, 16'h0001);
    pulse();
    cyc(10);
    wr(4'h3, 16'h0001);
    cyc(60);
    check("fall", {15'h0000, irq}, 16'h0000);
    wr(4'h4, 16'h0000);
    pulse();
    cyc(10);
    check("masked", {15'h0000, irq}, 16'h0000);
    cyc(35);
    pulse();
    cyc(10);
    rd(4'h3);
    check("overrun status", d, 16'h000f);
    wr(4'h4, 16'h0002);
    check("overrun irq", {15'h0000, irq}, 16'h0001);
    wr(4'h3, 16'h0003);
    check("status clear", {15'h0000, irq}, 16'h0000);
  endtask : fallAndMask
  task automatic regAccess();
    wr(4'h0, 16'h0003);
    rd(4'h0);
    check("count select", d, 16'h0002);
    rd(4'h1);
    check("pin count", d, 16'h0000);
    wr(4'h0, 16'h0004);
    wr(4'h2, 16'h1234);
    rd(4'h2);
    check("capture rw", d, 16'h1234);
    wr(4'h1, 16'hbeef);
    rd(4'h1);
    check("counter ro", d, 16'h0000);
  endtask : regAccess
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial
  begin
    cyc(5);
    reset_n <= 1'b1;
    cyc(1);
    resetValues();
    measure();
    fallAndMask();
    regAccess();
    summarize();
  end
  initial
  begin
    cyc(5000);
    num_errors++;
    summarize();
  end
endmodule : pulse_interval_capture_tb
bind pulse_interval_capture pulse_interval_capture_properties
  #(.COUNT_WIDTH(COUNT_WIDTH)) i_props (.sys_clk(sys_clk),
  .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .pulseInputPin(pulseInputPin), .captureCompleteIrq(captureCompleteIrq));
